// ### hw/dmaevm_pkg.sv
`default_nettype none
package dmaevm_pkg;
	// ----------------------------------------------------------------
	// Register map and field layout
	// ----------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFF_SELECT_0 = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SELECT_1 = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_SELECT_3 = 4'hc;
	localparam int NUM_CHAN = 16;
	localparam int CODE_W = 6;
	localparam int NUM_CODES = 64;
	localparam int FIELD_STRIDE = 8;
	localparam int FIELDS_PER_REG = 4;
	localparam logic [31:0] SEL_RESERVED_MASK = 32'hc0c0c0c0;
	// ----------------------------------------------------------------
	// Reset values: every channel starts on the code of its own index
	// ----------------------------------------------------------------
	localparam logic [31:0] SELECT_0_RESET = 32'h03020100;
	localparam logic [31:0] SELECT_1_RESET = 32'h07060504;
	localparam logic [31:0] SELECT_3_RESET = 32'h0f0e0d0c;
	// ----------------------------------------------------------------
	// Event codes
	// ----------------------------------------------------------------
	localparam logic [NUM_CODES-1:0] CODE_VALID = 64'h0000_0000_0000_f4ff;
	localparam logic [NUM_CHAN-1:0] CHAIN_CHAN_MASK = 16'h0f00;
	localparam int CODE_HOST = 0;
	localparam int CODE_TIMER0 = 1;
	localparam int CODE_TIMER1 = 2;
	localparam int CODE_MEMIF = 3;
	localparam int CODE_GPIO4 = 4;
	localparam int CODE_GPIO2 = 10;
	localparam int CODE_SER0_XMIT = 12;
	localparam int CODE_SER0_RECV = 13;
	localparam int CODE_SER1_XMIT = 14;
	localparam int CODE_SER1_RECV = 15;
	localparam int CHAIN_BASE = 8;
	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic hostEvent;
		logic timer0Event;
		logic timer1Event;
		logic memIfEvent;
		logic serial0XmitEvent;
		logic serial0RecvEvent;
		logic serial1XmitEvent;
		logic serial1RecvEvent;
	} dmaevm_src_type;
	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} dmaevm_apb_req_type;
endpackage : dmaevm_pkg
`default_nettype wire

// ### hw/dmaevm_chan_sel.sv
`default_nettype none
// One channel's selector: picks the event named by its code, valid codes only
module dmaevm_chan_sel (
	input wire logic [dmaevm_pkg::CODE_W-1:0] code,
	input wire logic [dmaevm_pkg::NUM_CODES-1:0] eventVec,
	output logic hit
);
	import dmaevm_pkg::*;
	// Reserved codes are masked so stray sources can never fire a channel
	assign hit = eventVec[code] & CODE_VALID[code];
endmodule : dmaevm_chan_sel
`default_nettype wire

// ### hw/dmaevm_top.sv
`default_nettype none
// Overview of operation
// - Six-bit code field per channel at bits 29:24, 21:16, 13:8, 5:0.
// - Bits 31:30, 23:22, 15:14, 7:6 read zero and ignore writes.
// - Field n steers channel n, for channels 0 through 7 and 12 through 15; 8 to 11 have no field.
// - Channels 0 to 7 and 12 to 15 fire when the event matching their programmed code occurs; 8 to 11 fire on their chaining event.
// - Five GPIO codes: codes 4 through 7 come from general-purpose pins 4 through 7, and code 10 from pin 2.
module dmaevm_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire dmaevm_pkg::dmaevm_apb_req_type apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dmaevm_pkg::dmaevm_src_type srcEvents,
	input wire logic [3:0] gpioPinHigh,
	input wire logic gpioPin2,
	input wire logic [3:0] chainEvent,
	output logic [dmaevm_pkg::NUM_CHAN-1:0] chanTrigger
);
	import dmaevm_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [CODE_W-1:0] selCode_r [NUM_CHAN];
	logic [4:0] pinSync1_r;
	logic [4:0] pinSync2_r;
	logic [4:0] pinLast_r;
	logic [4:0] pinRise;
	logic [NUM_CODES-1:0] eventVec;
	logic [NUM_CHAN-1:0] chanHit;
	logic [31:0] prdata_nxt;
	logic pslverr_nxt;
	logic setupPhase;
	logic accessDone;
	logic [1:0] regIdx;

	assign setupPhase = apbReq.psel & ~apbReq.penable;
	assign accessDone = apbReq.psel & apbReq.penable & pready;
	assign regIdx = apbReq.paddr[3:2];

	// ----------------------------------------------------------------
	// GPIO pin capture
	// ----------------------------------------------------------------
	// Pins are asynchronous, so two flops before the edge detector
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pinSync1_r <= 5'h00;
			pinSync2_r <= 5'h00;
			pinLast_r <= 5'h00;
		end else begin
			pinSync1_r <= {gpioPinHigh, gpioPin2};
			pinSync2_r <= pinSync1_r;
			pinLast_r <= pinSync2_r;
		end
	end

	// Rising edge gives a one-cycle event, like the on-chip sources
	assign pinRise = pinSync2_r & ~pinLast_r;

	// ----------------------------------------------------------------
	// Event vector indexed by selector code
	// ----------------------------------------------------------------
	always_comb begin
		eventVec = '0;
		eventVec[CODE_HOST] = srcEvents.hostEvent;
		eventVec[CODE_TIMER0] = srcEvents.timer0Event;
		eventVec[CODE_TIMER1] = srcEvents.timer1Event;
		eventVec[CODE_MEMIF] = srcEvents.memIfEvent;
		eventVec[CODE_GPIO4 +: 4] = pinRise[4:1];
		eventVec[CODE_GPIO2] = pinRise[0];
		eventVec[CODE_SER0_XMIT] = srcEvents.serial0XmitEvent;
		eventVec[CODE_SER0_RECV] = srcEvents.serial0RecvEvent;
		eventVec[CODE_SER1_XMIT] = srcEvents.serial1XmitEvent;
		eventVec[CODE_SER1_RECV] = srcEvents.serial1RecvEvent;
	end

	// ----------------------------------------------------------------
	// Per-channel selection
	// ----------------------------------------------------------------
	// Channels 8 to 11 have no selector; their chaining event passes straight
	for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : gChan
		if (CHAIN_CHAN_MASK[ch]) begin : gChain
			assign chanHit[ch] = chainEvent[ch-CHAIN_BASE];
		end else begin : gSel
			dmaevm_chan_sel uSel (
				.code(selCode_r[ch]),
				.eventVec(eventVec),
				.hit(chanHit[ch])
			);
		end
	end

	// One register stage: trigger lands on the edge after the event
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			chanTrigger <= '0;
		end else begin
			chanTrigger <= chanHit;
		end
	end

	// ----------------------------------------------------------------
	// Selector registers
	// ----------------------------------------------------------------
	// Writes land only on the completing access edge; reserved bits dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int c = 0; c < NUM_CHAN; c++) begin
				selCode_r[c] <= CODE_W'(c);
			end
		end else if (accessDone && apbReq.pwrite && !pslverr) begin
			for (int k = 0; k < FIELDS_PER_REG; k++) begin
				selCode_r[regIdx*FIELDS_PER_REG+k] <=
					apbReq.pwdata[k*FIELD_STRIDE +: CODE_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// APB read data and answer
	// ----------------------------------------------------------------
	// Decode in setup, answer from flops in the first access cycle
	always_comb begin
		prdata_nxt = 32'h00000000;
		pslverr_nxt = 1'b0;
		if (apbReq.paddr == OFF_SELECT_0 || apbReq.paddr == OFF_SELECT_1 ||
			apbReq.paddr == OFF_SELECT_3) begin
			for (int k = 0; k < FIELDS_PER_REG; k++) begin
				prdata_nxt[k*FIELD_STRIDE +: CODE_W] =
					selCode_r[regIdx*FIELDS_PER_REG+k];
			end
			prdata_nxt = prdata_nxt & ~SEL_RESERVED_MASK;
		end else begin
			pslverr_nxt = 1'b1;
		end
	end

	// Fixed one-cycle access phase keeps the slave free of wait logic
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setupPhase;
			pslverr <= setupPhase & pslverr_nxt;
			if (setupPhase && !apbReq.pwrite) begin
				prdata <= prdata_nxt;
			end
		end
	end
endmodule : dmaevm_top
`default_nettype wire

// ### dv/dmaevm_sva.sv
`default_nettype none
module dmaevm_sva
	import dmaevm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire dmaevm_pkg::dmaevm_apb_req_type apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire dmaevm_pkg::dmaevm_src_type srcEvents,
	input wire logic [3:0] gpioPinHigh,
	input wire logic [3:0] chainEvent,
	input wire logic [15:0] chanTrigger
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] code_r [16];
	logic [15:0] expTrig_r, chkMask_r, rsvMask_r, ev;
	logic [3:0] b;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Event vector by code; pin-sourced codes are left out, only code 4 on channel 4 has its own check
	assign ev = {<<{srcEvents[7:4], 8'h00, srcEvents[3:0]}};
	assign b = {apbReq.paddr[3:2], 2'b00};
	// Shadow of the programmed codes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int n = 0; n < 16; n++) code_r[n] <= 6'(n);
		end else if (pready && !pslverr && apbReq.pwrite) begin
			for (int k = 0; k < 4; k++) code_r[b + 4'(k)] <= apbReq.pwdata[8*k+:6];
		end
	end
	// Expected triggers one clock after the event
	always_ff @(posedge clk or negedge rst_b) begin
		for (int n = 0; n < 16; n++) begin
			expTrig_r[n] <= rst_b && (n/4 == 2 ? chainEvent[n%4] : code_r[n] < 16 && ev[code_r[n][3:0]]);
			chkMask_r[n] <= n/4 == 2 || !(code_r[n] inside {[4:7], 10});
			rsvMask_r[n] <= n/4 != 2 && !CODE_VALID[code_r[n]];
		end
	end
	// ------
	// Checks
	// ------
	property p_fld;
		pready && !apbReq.pwrite && !pslverr |-> (prdata & ~SEL_RESERVED_MASK) ==
			{2'b0, code_r[b+3], 2'b0, code_r[b+2], 2'b0, code_r[b+1], 2'b0, code_r[b]};
	endproperty
	a_fld: assert property (p_fld) else $error("read field mismatch");
	property p_rsv;
		pready && !apbReq.pwrite |-> (prdata & SEL_RESERVED_MASK) == 32'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_map;
		(chanTrigger & chkMask_r) == (expTrig_r & chkMask_r);
	endproperty
	a_map: assert property (p_map) else $error("trigger mismatch");
	property p_rcd;
		(chanTrigger & rsvMask_r) == 16'h0;
	endproperty
	a_rcd: assert property (p_rcd) else $error("reserved code fired");
	property p_lat;
		srcEvents.timer0Event && code_r[1] == 6'h01 |=> chanTrigger[1];
	endproperty
	a_lat: assert property (p_lat) else $error("late trigger");
	property p_gpio;
		$rose(gpioPinHigh[0]) && code_r[4] == 6'h04 |-> ##[1:5] chanTrigger[4];
	endproperty
	a_gpio: assert property (p_gpio) else $error("pin event lost");
	c_wr: cover property (pready && apbReq.pwrite);
	c_err: cover property (pready && pslverr);
	c_pin: cover property (chanTrigger[4]);
endmodule : dmaevm_sva
bind dmaevm_top dmaevm_sva u_dmaevm_sva (.clk(clk), .rst_b(rst_b), .apbReq(apbReq),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .srcEvents(srcEvents),
	.gpioPinHigh(gpioPinHigh), .chainEvent(chainEvent), .chanTrigger(chanTrigger));
`default_nettype wire

// ### dv/dmaevm_dma_model.sv
`default_nettype none
module dmaevm_dma_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] trig,
	output logic [3:0] hits [16]
);
	timeunit 1ns;
	timeprecision 1ns;
	// Count triggers per channel; wraps past 15, enough for short runs
	always_ff @(posedge clk or negedge rst_b) begin
		for (int n = 0; n < 16; n++) hits[n] <= rst_b ? hits[n] + 4'(trig[n]) : 4'h0;
	end
endmodule : dmaevm_dma_model
`default_nettype wire

// ### dv/tb.sv
`default_nettype none
module tb;
	import dmaevm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, pready, pslverr, e, gpioPin2;
	logic [31:0] prdata, q;
	logic [3:0] gpioPinHigh, chainEvent;
	logic [15:0] chanTrigger;
	logic [3:0] hits [16];
	dmaevm_apb_req_type apbReq;
	dmaevm_src_type srcEvents;
	int errCount, nChecks;
	dmaevm_top u_dmaevm_top (.clk(clk), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .srcEvents(srcEvents), .gpioPinHigh(gpioPinHigh),
		.gpioPin2(gpioPin2), .chainEvent(chainEvent), .chanTrigger(chanTrigger));
	dmaevm_dma_model u_dmaevm_dma_model (.clk(clk), .rst_b(rst_b), .trig(chanTrigger), .hits(hits));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
		nChecks++;
		if (sn !== ex) begin
			errCount++;
			$display("wrong value %s exp %h got %h", nm, ex, sn);
		end
	endtask : chk
	// One APB transfer; waits for pready, watchdog bounds the wait
	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
		@(posedge clk) apbReq <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk) apbReq.penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask : xfer
	task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic ee);
		xfer(a, 1'b0, 32'h0);
		chk("prdata", ex, q);
		chk("pslverr", 32'(ee), 32'(e));
	endtask : rd
	task report_and_stop;
		if (errCount == 0 && nChecks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	// ----
	// Main
	// ----
	initial begin
		{apbReq, srcEvents, gpioPinHigh, gpioPin2, chainEvent, rst_b} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		rd(OFF_SELECT_0, SELECT_0_RESET, 1'b0);
		rd(OFF_SELECT_1, SELECT_1_RESET, 1'b0);
		rd(OFF_SELECT_3, SELECT_3_RESET, 1'b0);
		rd(4'h8, 32'h0, 1'b1);
		// Every on-chip source once, reset codes route each to its own channel
		@(posedge clk) srcEvents <= 8'hff;
		@(posedge clk) srcEvents <= '0;
		repeat (4) @(posedge clk);
		for (int n = 0; n < 16; n++) chk("hits", 32'(16'hf00f >> n & 1), 32'(hits[n]));
		xfer(4'h8, 1'b1, 32'hffffffff);
		chk("pslverr", 32'h1, 32'(e));
		rd(OFF_SELECT_0, SELECT_0_RESET, 1'b0);
		xfer(OFF_SELECT_3, 1'b1, 32'hffffffff);
		rd(OFF_SELECT_3, 32'h3f3f3f3f, 1'b0);
		xfer(OFF_SELECT_3, 1'b1, 32'h01010101);
		xfer(OFF_SELECT_0, 1'b1, 32'h03020109);
		xfer(OFF_SELECT_1, 1'b1, 32'h07060a04);
		rd(OFF_SELECT_0, 32'h03020109, 1'b0);
		// Shared timer code, reserved code, both pin kinds and chaining at once
		@(posedge clk) {srcEvents, chainEvent, gpioPinHigh, gpioPin2} <= {8'hc0, 4'hf, 4'h1, 1'b1};
		@(posedge clk) {srcEvents, chainEvent} <= '0;
		repeat (8) @(posedge clk);
		for (int n = 0; n < 16; n++) chk("hits", 32'((16'hff32 >> n & 1) + (16'hf00f >> n & 1)), 32'(hits[n]));
		report_and_stop;
	end
	initial begin
		repeat (2000) @(posedge clk);
		errCount++;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
